// >>> include/frc_pkg.sv
// Purpose: Shared constants and types for the file rotate and carry rotate unit
// Assumes: Operand memory of 256 words of 16 bits; bit space of 4096 bits over it
// Notes: All widths fixed; no software-visible registers
package frc_pkg;
  localparam int unsigned DATA_W = 16;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned BITA_W = 12;
  localparam int unsigned LEN_W = 9;
  localparam int unsigned CNT_W = 16;
  localparam int unsigned SPAN_W = 13;
  localparam int unsigned BITSEL_W = 4;
  localparam logic [CNT_W-1:0] CNT_MIN = 16'h0001;
  localparam logic [CNT_W-1:0] CNT_MAX = 16'h0010;
  localparam logic [LEN_W-1:0] LEN_MIN = 9'h001;
  localparam logic [LEN_W-1:0] LEN_MAX = 9'h100;
  localparam logic [SPAN_W-1:0] WORD_SPACE = 13'h0100;
  localparam logic [SPAN_W-1:0] BIT_SPACE = 13'h1000;
  localparam logic [DATA_W-1:0] DATA_RST = 16'h0000;

  typedef enum logic [1:0] {
    OP_FILE_ROTATE_RIGHT = 2'h0,
    OP_FILE_ROTATE_LEFT = 2'h1,
    OP_SINGLE_ROTATE_RIGHT_THRU_CARRY = 2'h2
  } frc_op_t;

  typedef enum logic [7:0] {
    ST_IDLE = 8'h01,
    ST_CP_RD = 8'h02,
    ST_CP_WR = 8'h04,
    ST_WB_RD = 8'h08,
    ST_WB_WR = 8'h10,
    ST_FIN = 8'h20,
    ST_RRC_RD = 8'h40,
    ST_RRC_WR = 8'h80
  } frc_state_t;
endpackage : frc_pkg

// >>> rtl/frc_mem.sv
// Purpose: Single-port word memory with registered read data
// Assumes: One access per cycle; read data valid the cycle after the address
// Notes: Frozen while ce is low
`timescale 1ns/1ps
module frc_mem (
  input wire logic clk,
  input wire logic ce,
  input wire logic we,
  input wire logic [frc_pkg::ADDR_W-1:0] addr,
  input wire logic [frc_pkg::DATA_W-1:0] wdata,
  output logic [frc_pkg::DATA_W-1:0] rdata
);
  import frc_pkg::*;

  logic [DATA_W-1:0] mem_q [0:(1<<ADDR_W)-1];

  always_ff @(posedge clk) begin
    if (ce) begin
      if (we) begin
        mem_q[addr] <= wdata;
      end
      rdata <= mem_q[addr];
    end
  end
endmodule : frc_mem

// >>> rtl/frc_rotate_unit.sv
// Purpose: File rotate right/left and single-bit rotate right through carry
// Assumes: Requests and host memory port come from logic on clk; ext port used only while idle
// Notes: File is copied to scratch, then written back rotated; errors leave memory untouched
`timescale 1ns/1ps
module frc_rotate_unit (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic ce,
  input wire logic rung_on,
  input wire logic start,
  input wire frc_pkg::frc_op_t op,
  input wire logic bit_mode,
  input wire logic [frc_pkg::BITA_W-1:0] base,
  input wire logic [frc_pkg::LEN_W-1:0] file_len,
  input wire logic [frc_pkg::CNT_W-1:0] rot_count,
  input wire logic carry_wr,
  input wire logic carry_wdata,
  input wire logic err_clr,
  input wire logic ext_we,
  input wire logic [frc_pkg::ADDR_W-1:0] ext_addr,
  input wire logic [frc_pkg::DATA_W-1:0] ext_wdata,
  output logic [frc_pkg::DATA_W-1:0] ext_rdata,
  output logic busy_q,
  output logic done_q,
  output logic rot_out_q,
  output logic carry_flag_q,
  output logic error_flag_q
);
  import frc_pkg::*;

  function automatic logic [SPAN_W-1:0] elem_pos(input logic [BITA_W-1:0] b, input logic [LEN_W-1:0] i);
    elem_pos = SPAN_W'({1'b0, b}) + SPAN_W'(i);
  endfunction : elem_pos

  function automatic logic [ADDR_W-1:0] word_of(input logic [BITA_W-1:0] b, input logic [LEN_W-1:0] i,
                                               input logic bm);
    logic [SPAN_W-1:0] p;
    p = elem_pos(b, i);
    word_of = bm ? p[BITA_W-1:BITSEL_W] : p[ADDR_W-1:0];
  endfunction : word_of

  function automatic logic [BITSEL_W-1:0] bit_of(input logic [BITA_W-1:0] b, input logic [LEN_W-1:0] i);
    logic [SPAN_W-1:0] p;
    p = elem_pos(b, i);
    bit_of = p[BITSEL_W-1:0];
  endfunction : bit_of

  frc_state_t state_q;
  frc_op_t op_q;
  logic bit_mode_q;
  logic [BITA_W-1:0] base_q;
  logic [LEN_W-1:0] len_q;
  logic [LEN_W-1:0] off_q;
  logic [LEN_W-1:0] idx_q;
  logic lsb_q;
  logic [DATA_W-1:0] m_rdata;
  logic [DATA_W-1:0] sc_rdata;
  logic m_we;
  logic [ADDR_W-1:0] m_addr;
  logic [DATA_W-1:0] m_wdata;
  logic sc_we;
  logic [ADDR_W-1:0] sc_addr;
  logic [DATA_W-1:0] sc_wdata;
  logic [LEN_W:0] src_sum;
  logic [LEN_W-1:0] src_idx;
  logic start_ok;
  logic cnt_err;
  logic len_err;
  logic span_err;
  logic nop_err;
  logic any_err;
  logic last_elem;
  logic [SPAN_W-1:0] span_end;
  logic [SPAN_W-1:0] space;

  assign start_ok = ce && start && rung_on && (state_q == ST_IDLE);
  assign cnt_err = (rot_count > CNT_MAX) || (rot_count < CNT_MIN);
  assign len_err = (file_len > LEN_MAX) || (file_len < LEN_MIN);
  assign span_end = elem_pos(base, file_len);
  assign space = bit_mode ? BIT_SPACE : WORD_SPACE;
  assign span_err = span_end > space;
  assign nop_err = rot_count > CNT_W'(file_len);
  assign any_err = (op != OP_SINGLE_ROTATE_RIGHT_THRU_CARRY) && (cnt_err || len_err || span_err || nop_err);
  assign last_elem = (idx_q == len_q - LEN_W'(1));

  // Source element for destination idx: right takes idx+k, left takes idx+m-k, modulo m
  assign src_sum = {1'b0, idx_q} + {1'b0, off_q};
  assign src_idx = (src_sum >= {1'b0, len_q}) ? LEN_W'(src_sum - {1'b0, len_q}) : src_sum[LEN_W-1:0];

  always_comb begin
    m_we = 1'b0;
    m_addr = ext_addr;
    m_wdata = ext_wdata;
    sc_we = 1'b0;
    sc_addr = idx_q[ADDR_W-1:0];
    sc_wdata = DATA_RST;
    unique case (state_q)
      ST_IDLE: begin
        m_we = ext_we;
      end
      ST_CP_RD, ST_WB_RD: begin
        m_addr = word_of(base_q, idx_q, bit_mode_q);
        sc_addr = src_idx[ADDR_W-1:0];
      end
      ST_CP_WR: begin
        sc_we = 1'b1;
        // Bit elements live in bit 0 of scratch words
        sc_wdata = bit_mode_q ? {{(DATA_W-1){1'b0}}, m_rdata[bit_of(base_q, idx_q)]} : m_rdata;
      end
      ST_WB_WR: begin
        m_we = 1'b1;
        m_addr = word_of(base_q, idx_q, bit_mode_q);
        m_wdata = sc_rdata;
        if (bit_mode_q) begin
          m_wdata = m_rdata;
          m_wdata[bit_of(base_q, idx_q)] = sc_rdata[0];
        end
      end
      ST_FIN: begin
      end
      ST_RRC_RD: begin
        m_addr = base_q[ADDR_W-1:0];
      end
      ST_RRC_WR: begin
        m_we = 1'b1;
        m_addr = base_q[ADDR_W-1:0];
        m_wdata = {carry_flag_q, m_rdata[DATA_W-1:1]};
      end
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= ST_IDLE;
    end else if (ce) begin
      unique case (state_q)
        ST_IDLE: begin
          if (start_ok && !any_err) begin
            state_q <= (op == OP_SINGLE_ROTATE_RIGHT_THRU_CARRY) ? ST_RRC_RD : ST_CP_RD;
          end
        end
        ST_CP_RD: state_q <= ST_CP_WR;
        ST_CP_WR: state_q <= last_elem ? ST_WB_RD : ST_CP_RD;
        ST_WB_RD: state_q <= ST_WB_WR;
        ST_WB_WR: state_q <= last_elem ? ST_FIN : ST_WB_RD;
        ST_FIN: state_q <= ST_IDLE;
        ST_RRC_RD: state_q <= ST_RRC_WR;
        ST_RRC_WR: state_q <= ST_IDLE;
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      op_q <= OP_FILE_ROTATE_RIGHT;
      bit_mode_q <= 1'b0;
      base_q <= '0;
      len_q <= LEN_MIN;
      off_q <= '0;
    end else if (ce && start_ok) begin
      op_q <= op;
      bit_mode_q <= bit_mode;
      base_q <= base;
      len_q <= file_len;
      off_q <= (op == OP_FILE_ROTATE_LEFT) ? LEN_W'(file_len - LEN_W'(rot_count)) : LEN_W'(rot_count);
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      idx_q <= '0;
    end else if (ce) begin
      if (start_ok) begin
        idx_q <= '0;
      end else if (state_q == ST_CP_WR || state_q == ST_WB_WR) begin
        idx_q <= last_elem ? '0 : idx_q + LEN_W'(1);
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      lsb_q <= 1'b0;
    end else if (ce && state_q == ST_WB_WR && idx_q == '0) begin
      lsb_q <= sc_rdata[0];
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      carry_flag_q <= 1'b0;
    end else if (ce) begin
      if (state_q == ST_RRC_WR) begin
        carry_flag_q <= m_rdata[0];
      end else if (state_q == ST_WB_WR && bit_mode_q && op_q == OP_FILE_ROTATE_RIGHT && last_elem) begin
        carry_flag_q <= sc_rdata[0];
      end else if (state_q == ST_WB_WR && bit_mode_q && op_q == OP_FILE_ROTATE_LEFT && idx_q == '0) begin
        carry_flag_q <= sc_rdata[0];
      end else if (carry_wr && state_q == ST_IDLE) begin
        carry_flag_q <= carry_wdata;
      end
    end
  end

  // Set wins over a clear in the same cycle
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      error_flag_q <= 1'b0;
    end else if (ce) begin
      if (start_ok && any_err) begin
        error_flag_q <= 1'b1;
      end else if (err_clr) begin
        error_flag_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rot_out_q <= 1'b0;
    end else if (ce) begin
      if (!rung_on) begin
        rot_out_q <= 1'b0;
      end else if (start_ok && any_err) begin
        rot_out_q <= 1'b0;
      end else if (state_q == ST_FIN) begin
        rot_out_q <= lsb_q;
      end else if (state_q == ST_RRC_WR) begin
        rot_out_q <= m_rdata[1];
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      busy_q <= 1'b0;
      done_q <= 1'b0;
    end else if (ce) begin
      busy_q <= (start_ok && !any_err) || (state_q != ST_IDLE && state_q != ST_FIN && state_q != ST_RRC_WR);
      done_q <= (start_ok && any_err) || state_q == ST_FIN || state_q == ST_RRC_WR;
    end
  end

  frc_mem u_main_mem (
    .clk(clk),
    .ce(ce),
    .we(m_we),
    .addr(m_addr),
    .wdata(m_wdata),
    .rdata(m_rdata)
  );

  frc_mem u_scratch_mem (
    .clk(clk),
    .ce(ce),
    .we(sc_we),
    .addr(sc_addr),
    .wdata(sc_wdata),
    .rdata(sc_rdata)
  );

  assign ext_rdata = m_rdata;

  sequence s_wb_step;
    (state_q == ST_WB_RD) && ce ##1 (state_q == ST_WB_WR) && ce;
  endsequence

  property p_src_wrap;
    @(posedge clk) disable iff (!arst_n) s_wb_step |-> (src_idx < len_q);
  endproperty
  a_src_wrap: assert property (p_src_wrap) else $error("Source index outside file");

  property p_rung_off;
    @(posedge clk) disable iff (!arst_n) (!rung_on && ce) |=> !rot_out_q;
  endproperty
  a_rung_off: assert property (p_rung_off) else $error("Output on with rung off");

  property p_cnt_err;
    @(posedge clk) disable iff (!arst_n)
      (start_ok && op != OP_SINGLE_ROTATE_RIGHT_THRU_CARRY && rot_count > CNT_MAX) |=> error_flag_q && !busy_q && done_q;
  endproperty
  a_cnt_err: assert property (p_cnt_err) else $error("Count overflow not flagged");

  property p_nop;
    @(posedge clk) disable iff (!arst_n)
      (start_ok && op != OP_SINGLE_ROTATE_RIGHT_THRU_CARRY && nop_err) |=> error_flag_q && !rot_out_q && state_q == ST_IDLE;
  endproperty
  a_nop: assert property (p_nop) else $error("Count above length executed");

  property p_word_carry;
    @(posedge clk) disable iff (!arst_n)
      (ce && !bit_mode_q && (state_q == ST_WB_WR || state_q == ST_CP_WR)) |=> $stable(carry_flag_q);
  endproperty
  a_word_carry: assert property (p_word_carry) else $error("Word rotate changed carry");

  property p_right_carry;
    @(posedge clk) disable iff (!arst_n)
      (ce && state_q == ST_WB_WR && bit_mode_q && op_q == OP_FILE_ROTATE_RIGHT && last_elem)
      |=> carry_flag_q == $past(sc_rdata[0]);
  endproperty
  a_right_carry: assert property (p_right_carry) else $error("Right bit rotate carry wrong");

  property p_left_carry;
    @(posedge clk) disable iff (!arst_n)
      (ce && state_q == ST_WB_WR && bit_mode_q && op_q == OP_FILE_ROTATE_LEFT && idx_q == '0)
      |=> carry_flag_q == $past(sc_rdata[0]);
  endproperty
  a_left_carry: assert property (p_left_carry) else $error("Left bit rotate carry wrong");

  sequence s_rrc;
    (state_q == ST_RRC_RD) && ce ##1 (state_q == ST_RRC_WR) && ce;
  endsequence

  property p_rrc;
    @(posedge clk) disable iff (!arst_n)
      s_rrc ##0 rung_on |=> carry_flag_q == $past(m_rdata[0]) && rot_out_q == $past(m_rdata[1]) && done_q;
  endproperty
  a_rrc: assert property (p_rrc) else $error("Carry rotate result wrong");

  property p_fin_out;
    @(posedge clk) disable iff (!arst_n)
      (ce && state_q == ST_FIN && rung_on) |=> rot_out_q == $past(lsb_q) && done_q;
  endproperty
  a_fin_out: assert property (p_fin_out) else $error("File rotate output wrong");
endmodule : frc_rotate_unit

// >>> tb/frc_rotate_unit_tb.sv
// Purpose: Self-checking bench for the file rotate and carry rotate unit
// Assumes: Inputs driven on the falling edge; memory loaded through the host port
// Notes: Behavioural model with queues; memory fully read back after every operation
`timescale 1ns/1ps
module frc_rotate_unit_tb;
  import frc_pkg::*;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic ce = 1'b1;
  logic rung_on = 1'b0, start = 1'b0, bit_mode = 1'b0;
  frc_op_t op = OP_FILE_ROTATE_RIGHT;
  logic [BITA_W-1:0] base = 12'h000;
  logic [LEN_W-1:0] file_len = 9'h000;
  logic [CNT_W-1:0] rot_count = 16'h0000;
  logic carry_wr = 1'b0, carry_wdata = 1'b0, err_clr = 1'b0, ext_we = 1'b0;
  logic [ADDR_W-1:0] ext_addr = 8'h00;
  logic [DATA_W-1:0] ext_wdata = 16'h0000;
  logic [DATA_W-1:0] ext_rdata;
  logic busy_q, done_q, rot_out_q, carry_flag_q, error_flag_q;
  logic [31:0] lfsr_state = 32'h2F82F444;
  logic [DATA_W-1:0] mdl [256];
  logic mdl_carry = 1'b0;
  int error_cnt = 0;
  int num_checks = 0;

  always #2.5 clk = ~clk;

  frc_rotate_unit dut (.clk(clk), .arst_n(arst_n), .ce(ce), .rung_on(rung_on), .start(start), .op(op),
    .bit_mode(bit_mode), .base(base), .file_len(file_len), .rot_count(rot_count), .carry_wr(carry_wr),
    .carry_wdata(carry_wdata), .err_clr(err_clr), .ext_we(ext_we), .ext_addr(ext_addr), .ext_wdata(ext_wdata),
    .ext_rdata(ext_rdata), .busy_q(busy_q), .done_q(done_q), .rot_out_q(rot_out_q),
    .carry_flag_q(carry_flag_q), .error_flag_q(error_flag_q));

  function automatic logic [31:0] rnd();
    lfsr_state = {lfsr_state[30:0], ^(lfsr_state & 32'h80200003)};
    return lfsr_state;
  endfunction : rnd

  task automatic final_report();
    $display("Checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : final_report

  task automatic check(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] t=%0t %s got=%h exp=%h", $time, what, got, exp);
    end
  endtask : check

  task automatic ext_write(input int a, input logic [DATA_W-1:0] d);
    @(negedge clk);
    ext_addr = a[7:0];
    ext_wdata = d;
    ext_we = 1'b1;
    mdl[a] = d;
    @(negedge clk);
    ext_we = 1'b0;
  endtask : ext_write

  // Pipelined read-back: data for the previous address is seen one cycle later
  task automatic mem_cmp();
    for (int i = 0; i <= 256; i++) begin
      @(negedge clk);
      if (i > 0) begin
        check(ext_rdata, mdl[i-1], "mem");
      end
      ext_addr = 8'(i);
    end
  endtask : mem_cmp

  task automatic run_op(input frc_op_t o, input logic bm, input int b, input int m, input int k, input logic cin);
    logic exp_err;
    logic exp_out;
    logic [DATA_W-1:0] w;
    int n;
    int lat;
    logic [DATA_W-1:0] el[$];
    logic [DATA_W-1:0] dst[$];
    @(negedge clk);
    carry_wr = 1'b1;
    carry_wdata = cin;
    err_clr = 1'b1;
    @(negedge clk);
    carry_wr = 1'b0;
    op = o;
    bit_mode = bm;
    base = 12'(b);
    file_len = 9'(m);
    rot_count = 16'(k);
    start = 1'b1;
    @(negedge clk);
    start = 1'b0;
    // Clear held through the start edge: a reject must still set the flag
    err_clr = 1'b0;
    mdl_carry = cin;
    exp_err = 1'b0;
    exp_out = 1'b0;
    lat = 4 * m + 2;
    if (o == OP_SINGLE_ROTATE_RIGHT_THRU_CARRY) begin
      w = mdl[b % 256];
      mdl[b % 256] = {cin, w[15:1]};
      mdl_carry = w[0];
      exp_out = w[1];
      lat = 3;
    end else if (k < 1 || k > 16 || m < 1 || m > 256 || k > m || b + m > (bm ? 4096 : 256)) begin
      exp_err = 1'b1;
      lat = 1;
    end else begin
      for (int i = 0; i < m; i++) begin
        el.push_back(bm ? 16'(mdl[(b + i) / 16][(b + i) % 16]) : mdl[b + i]);
      end
      for (int i = 0; i < m; i++) begin
        dst.push_back(o == OP_FILE_ROTATE_RIGHT ? el[(i + k) % m] : el[(i - k + m) % m]);
      end
      for (int i = 0; i < m; i++) begin
        if (bm) begin
          mdl[(b + i) / 16][(b + i) % 16] = dst[i][0];
        end else begin
          mdl[b + i] = dst[i];
        end
      end
      exp_out = dst[0][0];
      if (bm) begin
        mdl_carry = (o == OP_FILE_ROTATE_RIGHT) ? dst[m-1][0] : dst[0][0];
      end
    end
    // Counts cycles from the start edge to the done pulse
    for (n = 1; n < 5000 && done_q !== 1'b1; n++) begin
      @(negedge clk);
    end
    if (n >= 5000) begin
      error_cnt++;
      final_report();
    end
    check(16'(n), 16'(lat), "latency");
    check(16'(busy_q), 16'h0000, "busy");
    check(16'(rot_out_q), 16'(exp_out), "rot_out");
    check(16'(carry_flag_q), 16'(mdl_carry), "carry");
    check(16'(error_flag_q), 16'(exp_err), "error");
    mem_cmp();
    $display("Test op=%0d bm=%0d base=%0d m=%0d k=%0d done", o, bm, b, m, k);
  endtask : run_op

  initial begin
    logic [31:0] r;
    int m;
    int k;
    int b;
    logic bm;
    repeat (10) @(negedge clk);
    check({11'h000, busy_q, done_q, rot_out_q, carry_flag_q, error_flag_q}, 16'h0000, "reset");
    arst_n = 1'b1;
    rung_on = 1'b1;
    for (int i = 0; i < 256; i++) begin
      ext_write(i, 16'(rnd()));
    end
    mem_cmp();
    run_op(OP_FILE_ROTATE_RIGHT, 1'b0, 3, 4, 2, 1'b1);
    run_op(OP_FILE_ROTATE_LEFT, 1'b0, 2, 5, 2, 1'b0);
    run_op(OP_FILE_ROTATE_RIGHT, 1'b0, 0, 256, 16, 1'b0);
    run_op(OP_FILE_ROTATE_LEFT, 1'b0, 255, 1, 1, 1'b1);
    run_op(OP_FILE_ROTATE_RIGHT, 1'b1, 3, 5, 2, 1'b0);
    run_op(OP_FILE_ROTATE_LEFT, 1'b1, 2, 6, 2, 1'b1);
    run_op(OP_FILE_ROTATE_LEFT, 1'b1, 4090, 6, 3, 1'b0);
    run_op(OP_FILE_ROTATE_RIGHT, 1'b0, 0, 20, 17, 1'b1);
    run_op(OP_FILE_ROTATE_LEFT, 1'b0, 0, 20, 0, 1'b0);
    run_op(OP_FILE_ROTATE_RIGHT, 1'b0, 8, 4, 5, 1'b1);
    run_op(OP_FILE_ROTATE_LEFT, 1'b0, 250, 7, 2, 1'b0);
    run_op(OP_FILE_ROTATE_RIGHT, 1'b1, 4091, 6, 2, 1'b1);
    run_op(OP_FILE_ROTATE_LEFT, 1'b0, 5, 0, 1, 1'b0);
    ext_write(64, 16'h0000);
    run_op(OP_SINGLE_ROTATE_RIGHT_THRU_CARRY, 1'b0, 64, 0, 0, 1'b1);
    ext_write(65, 16'hFFFF);
    run_op(OP_SINGLE_ROTATE_RIGHT_THRU_CARRY, 1'b0, 65, 0, 0, 1'b0);
    for (int j = 0; j < 10; j++) begin
      r = rnd();
      m = 1 + r[4:0];
      k = r[9:5] % 18;
      bm = r[10];
      b = bm ? r[27:16] % (4097 - m) : r[23:16] % (257 - m);
      run_op(frc_op_t'(r[12:11] % 3), bm, b, m, k, r[13]);
    end
    ext_write(66, 16'h0003);
    run_op(OP_SINGLE_ROTATE_RIGHT_THRU_CARRY, 1'b0, 66, 0, 0, 1'b1);
    // Clock enable low: requests, host writes and carry writes must all be frozen
    @(negedge clk);
    ce = 1'b0;
    start = 1'b1;
    op = OP_FILE_ROTATE_RIGHT;
    base = 12'h000;
    file_len = 9'h004;
    rot_count = 16'h0001;
    carry_wr = 1'b1;
    carry_wdata = ~mdl_carry;
    ext_we = 1'b1;
    ext_addr = 8'h10;
    ext_wdata = ~mdl[16];
    repeat (8) begin
      @(negedge clk);
      check({13'h0000, busy_q, done_q, carry_flag_q}, {15'h0000, mdl_carry}, "frozen");
    end
    ce = 1'b1;
    start = 1'b0;
    carry_wr = 1'b0;
    ext_we = 1'b0;
    mem_cmp();
    $display("Test clock enable hold done");
    @(negedge clk);
    rung_on = 1'b0;
    start = 1'b1;
    op = OP_FILE_ROTATE_RIGHT;
    base = 12'h000;
    file_len = 9'h004;
    rot_count = 16'h0001;
    @(negedge clk);
    start = 1'b0;
    repeat (10) begin
      @(negedge clk);
      check({14'h0000, busy_q, rot_out_q}, 16'h0000, "rung off");
    end
    check(16'(carry_flag_q), 16'(mdl_carry), "rung off carry");
    check(16'(error_flag_q), 16'h0000, "rung off error");
    mem_cmp();
    $display("Test rung off done");
    final_report();
  end
endmodule : frc_rotate_unit_tb
